/* design/lpmc_pkg.sv */
// Package for the linear regulator power-mode decode block.
// Assumes an AXI4-Lite slave with 32-bit data; one byte register per word.
package lpmc_pkg;

  // Register indexes; the byte address on the bus is four times the index
  localparam logic [7:0]  LPMC_IDX_MODE_LOW  = 8'h98;
  localparam logic [7:0]  LPMC_IDX_MODE_HIGH = 8'h99;
  localparam logic [11:0] LPMC_ADDR_MODE_LOW  = {2'h0, LPMC_IDX_MODE_LOW, 2'h0};
  localparam logic [11:0] LPMC_ADDR_MODE_HIGH = {2'h0, LPMC_IDX_MODE_HIGH, 2'h0};
  localparam int          LPMC_ADDR_W = 12;

  // Factory-programmed values after reset, neutral defaults
  localparam logic [7:0]  LPMC_RST_MODE_LOW  = 8'h00;
  localparam logic [7:0]  LPMC_RST_MODE_HIGH = 8'h00;

  // Count of regulators and field width
  localparam int          LPMC_NREG = 8;
  localparam int          LPMC_FW   = 2;

  // Mode codes and the source code that means software control
  typedef enum logic [1:0]
  {
    LPMC_MODE_OFF    = 2'h0,
    LPMC_MODE_GLOBAL = 2'h1,
    LPMC_MODE_LOWPWR = 2'h2,
    LPMC_MODE_NORMAL = 2'h3
  } lpmc_mode_e;
  localparam logic [1:0]  LPMC_SRC_SOFT = 2'h3;

  // AXI responses
  localparam logic [1:0]  LPMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  LPMC_RESP_SLVERR = 2'h2;

  // Per-regulator decoded result
  typedef struct packed
  {
    logic enable;
    logic lowPower;
  } lpmc_out_s;

endpackage : lpmc_pkg

/* design/lpmc_top.sv */
// Linear regulator power-mode decode with an AXI4-Lite register slave.
// Assumes sequencer slot states and the global low-power level are synchronous.
// Overview of operation
// RQ1: Mode 00 keeps the regulator disabled.
// RQ2: Soft source, mode 01: on, follows global low-power.
// RQ3: Soft source, mode 10: on, forced low-power.
// RQ4: Soft source, mode 11: on, forced normal.
// RQ5: Sequencer source, nonzero mode: enable follows slot.
// RQ6: Sequencer, mode 01: low-power follows global signal; code keeps low-power at 0 while the slot is off.
// RQ7: Sequencer, mode 10: slot on gives low-power.
// RQ8: Sequencer, mode 11: slot on gives normal.
// RQ9: Two bytes hold fields, regulator 0 at top.
// RQ10: Outputs recomputed every cycle from current inputs.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module lpmc_top
#(
  parameter int NREG = lpmc_pkg::LPMC_NREG
)
(
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  // AXI4-Lite write address and data
  input  wire logic                            s_axi_awvalid,
  output      logic                            s_axi_awready,
  input  wire logic [lpmc_pkg::LPMC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                            s_axi_wvalid,
  output      logic                            s_axi_wready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  // AXI4-Lite write response
  output      logic                            s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output      logic [1:0]                      s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                            s_axi_arvalid,
  output      logic                            s_axi_arready,
  input  wire logic [lpmc_pkg::LPMC_ADDR_W-1:0] s_axi_araddr,
  output      logic                            s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output      logic [31:0]                     s_axi_rdata,
  output      logic [1:0]                      s_axi_rresp,
  // Regulator control inputs
  input  wire logic [2*NREG-1:0]               regulator_sequencer_source_select,
  input  wire logic [NREG-1:0]                 sequencerSlotOn,
  input  wire logic                            globalLowPower,
  // Regulator outputs
  output      logic [NREG-1:0]                 regulatorEnable,
  output      logic [NREG-1:0]                 regulatorLowPower
);
  import lpmc_pkg::*;

  // Decode one regulator from mode, source, slot and global level
  function automatic lpmc_out_s decode_mode(input logic [1:0] mode, input logic [1:0] src,
                                            input logic slot, input logic glp);
    lpmc_out_s o;
    o = '0;
    if (mode != LPMC_MODE_OFF) // RQ1
    begin
      o.enable = (src == LPMC_SRC_SOFT) ? 1'b1 : slot; // RQ2 RQ3 RQ4 RQ5
      unique case (lpmc_mode_e'(mode))
        LPMC_MODE_GLOBAL: o.lowPower = o.enable & glp; // RQ2 RQ6
        LPMC_MODE_LOWPWR: o.lowPower = o.enable;       // RQ3 RQ7
        LPMC_MODE_NORMAL: o.lowPower = 1'b0;           // RQ4 RQ8
        LPMC_MODE_OFF:    o.lowPower = 1'b0;
      endcase
    end
    return o;
  endfunction : decode_mode

  // Extract field n of the 16 bits; regulator 0 at bits 7:6 of low byte
  function automatic logic [1:0] field_of(input logic [15:0] modes, input int n);
    logic [3:0] pos;
    pos = 4'(n < 4 ? (3 - n) * 2 : 8 + (7 - n) * 2);
    return modes[pos +: 2];
  endfunction : field_of

  // Register state
  logic [7:0]  modeLow_reg,  modeLow_next;
  logic [7:0]  modeHigh_reg, modeHigh_next;
  logic        awHeld_reg,   awHeld_next;
  logic        wHeld_reg,    wHeld_next;
  logic [LPMC_ADDR_W-1:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg,    wData_next;
  logic [3:0]  wStrb_reg,    wStrb_next;
  logic        bValid_reg,   bValid_next;
  logic [1:0]  bResp_reg,    bResp_next;
  logic        rValid_reg,   rValid_next;
  logic [31:0] rData_reg,    rData_next;
  logic [1:0]  rResp_reg,    rResp_next;
  logic        awRdy_reg,    awRdy_next;
  logic        wRdy_reg,     wRdy_next;
  logic        arRdy_reg,    arRdy_next;
  logic [NREG-1:0] en_reg,   en_next;
  logic [NREG-1:0] lp_reg,   lp_next;
  logic [15:0] modesAll;
  logic        awTake;
  logic        wTake;
  logic        doWrite;

  assign modesAll = {modeHigh_reg, modeLow_reg};
  assign awTake   = s_axi_awvalid & awRdy_reg;
  assign wTake    = s_axi_wvalid & wRdy_reg;
  assign doWrite  = (awHeld_reg | awTake) & (wHeld_reg | wTake) & ~bValid_reg;

  // Write channel: accept address and data in either order, then respond
  always_comb
  begin
    logic [LPMC_ADDR_W-1:0] a;
    logic [7:0]             d;
    a             = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    d             = wHeld_reg ? wData_reg[7:0] : s_axi_wdata[7:0];
    awHeld_next   = awHeld_reg | awTake;
    wHeld_next    = wHeld_reg | wTake;
    awAddr_next   = awTake ? s_axi_awaddr : awAddr_reg;
    wData_next    = wTake ? s_axi_wdata : wData_reg;
    wStrb_next    = wTake ? s_axi_wstrb : wStrb_reg;
    bValid_next   = bValid_reg & ~s_axi_bready;
    bResp_next    = bResp_reg;
    modeLow_next  = modeLow_reg;
    modeHigh_next = modeHigh_reg;
    if (doWrite)
    begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = LPMC_RESP_OKAY;
      if ((wHeld_reg ? wStrb_reg[0] : s_axi_wstrb[0]) && a == LPMC_ADDR_MODE_LOW)
        modeLow_next = d; // RQ9
      else if ((wHeld_reg ? wStrb_reg[0] : s_axi_wstrb[0]) && a == LPMC_ADDR_MODE_HIGH)
        modeHigh_next = d; // RQ9
      else if (a != LPMC_ADDR_MODE_LOW && a != LPMC_ADDR_MODE_HIGH)
        bResp_next = LPMC_RESP_SLVERR;
    end
    // Ready worked out a cycle ahead so the pin comes from a flop
    awRdy_next    = ~awHeld_next & ~bValid_next;
    wRdy_next     = ~wHeld_next & ~bValid_next;
  end

  // Read channel: one-cycle answer, unmapped reads give SLVERR and zero
  always_comb
  begin
    rValid_next = rValid_reg & ~s_axi_rready;
    rData_next  = rData_reg;
    rResp_next  = rResp_reg;
    if (s_axi_arvalid && !rValid_reg)
    begin
      rValid_next = 1'b1;
      rResp_next  = LPMC_RESP_OKAY;
      if (s_axi_araddr == LPMC_ADDR_MODE_LOW)
        rData_next = {24'h000000, modeLow_reg}; // RQ9
      else if (s_axi_araddr == LPMC_ADDR_MODE_HIGH)
        rData_next = {24'h000000, modeHigh_reg}; // RQ9
      else
      begin
        rData_next = 32'h00000000;
        rResp_next = LPMC_RESP_SLVERR;
      end
    end
    // Address channel refused while a read answer stands
    arRdy_next = ~rValid_next;
  end

  // Per-regulator decode, evaluated every cycle
  always_comb
  begin
    lpmc_out_s r;
    r = '0;
    en_next = '0;
    lp_next = '0;
    for (int n = 0; n < NREG; n++)
    begin
      r = decode_mode(field_of(modesAll, n), regulator_sequencer_source_select[2*n +: 2],
                      sequencerSlotOn[n], globalLowPower); // RQ10
      en_next[n] = r.enable;
      lp_next[n] = r.lowPower;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      modeLow_reg  <= LPMC_RST_MODE_LOW;
      modeHigh_reg <= LPMC_RST_MODE_HIGH;
      awHeld_reg   <= 1'b0;
      wHeld_reg    <= 1'b0;
      awAddr_reg   <= '0;
      wData_reg    <= 32'h00000000;
      wStrb_reg    <= 4'h0;
      bValid_reg   <= 1'b0;
      bResp_reg    <= LPMC_RESP_OKAY;
      rValid_reg   <= 1'b0;
      rData_reg    <= 32'h00000000;
      rResp_reg    <= LPMC_RESP_OKAY;
      awRdy_reg    <= 1'b1;
      wRdy_reg     <= 1'b1;
      arRdy_reg    <= 1'b1;
      en_reg       <= '0;
      lp_reg       <= '0;
    end
    else
    begin
      modeLow_reg  <= modeLow_next;
      modeHigh_reg <= modeHigh_next;
      awHeld_reg   <= awHeld_next;
      wHeld_reg    <= wHeld_next;
      awAddr_reg   <= awAddr_next;
      wData_reg    <= wData_next;
      wStrb_reg    <= wStrb_next;
      bValid_reg   <= bValid_next;
      bResp_reg    <= bResp_next;
      rValid_reg   <= rValid_next;
      rData_reg    <= rData_next;
      rResp_reg    <= rResp_next;
      awRdy_reg    <= awRdy_next;
      wRdy_reg     <= wRdy_next;
      arRdy_reg    <= arRdy_next;
      en_reg       <= en_next;
      lp_reg       <= lp_next;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready     = awRdy_reg;
  assign s_axi_wready      = wRdy_reg;
  assign s_axi_bvalid      = bValid_reg;
  assign s_axi_bresp       = bResp_reg;
  assign s_axi_arready     = arRdy_reg;
  assign s_axi_rvalid      = rValid_reg;
  assign s_axi_rdata       = rData_reg;
  assign s_axi_rresp       = rResp_reg;
  assign regulatorEnable   = en_reg;
  assign regulatorLowPower = lp_reg;

  // Checks on regulator 0 and 7, and on the high mode byte write
  chk_off_disables: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    field_of(modesAll, 0) == 2'h0 |=> !regulatorEnable[0])
    else $error("regulator 0 enabled with mode off");
  chk_soft_global: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    field_of(modesAll, 0) == 2'h1 && regulator_sequencer_source_select[1:0] == 2'h3
    |=> regulatorEnable[0] && regulatorLowPower[0] == $past(globalLowPower))
    else $error("soft global mode wrong");
  chk_soft_lowpwr: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    field_of(modesAll, 0) == 2'h2 && regulator_sequencer_source_select[1:0] == 2'h3
    |=> regulatorEnable[0] && regulatorLowPower[0])
    else $error("soft forced low-power wrong");
  chk_soft_normal: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    field_of(modesAll, 7) == 2'h3 && regulator_sequencer_source_select[15:14] == 2'h3
    |=> regulatorEnable[7] && !regulatorLowPower[7])
    else $error("soft forced normal wrong");
  chk_seq_follow: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    field_of(modesAll, 7) != 2'h0 && regulator_sequencer_source_select[15:14] != 2'h3
    |=> regulatorEnable[7] == $past(sequencerSlotOn[7]))
    else $error("sequencer enable not followed");
  chk_seq_global: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    field_of(modesAll, 7) == 2'h1 && regulator_sequencer_source_select[15:14] != 2'h3
    && sequencerSlotOn[7] |=> regulatorLowPower[7] == $past(globalLowPower))
    else $error("sequencer global mode wrong");
  chk_seq_lowpwr: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    field_of(modesAll, 0) == 2'h2 && regulator_sequencer_source_select[1:0] != 2'h3
    && sequencerSlotOn[0] |=> regulatorEnable[0] && regulatorLowPower[0])
    else $error("sequencer low-power wrong");
  chk_seq_normal: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    field_of(modesAll, 0) == 2'h3 && regulator_sequencer_source_select[1:0] != 2'h3
    && sequencerSlotOn[0] |=> regulatorEnable[0] && !regulatorLowPower[0])
    else $error("sequencer normal wrong");
  chk_write_lands: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    doWrite && awAddr_next == LPMC_ADDR_MODE_HIGH && wStrb_next[0]
    |=> modeHigh_reg == $past(wData_next[7:0]))
    else $error("high mode byte not written");
  chk_prompt_update: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    $changed(globalLowPower) && field_of(modesAll, 7) == 2'h1
    && regulator_sequencer_source_select[15:14] == 2'h3
    |=> regulatorLowPower[7] == $past(globalLowPower))
    else $error("low-power output did not follow global change");
  chk_off_lowpower: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    field_of(modesAll, 7) == 2'h0
    |=> !regulatorEnable[7] && !regulatorLowPower[7])
    else $error("regulator 7 active with mode off");

  // Checks on the register slave
  chk_write_low: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    doWrite && awAddr_next == LPMC_ADDR_MODE_LOW && wStrb_next[0]
    |=> modeLow_reg == $past(wData_next[7:0]))
    else $error("low mode byte not written");
  chk_strobe_off: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    doWrite && !wStrb_next[0]
    |=> $stable(modeLow_reg) && $stable(modeHigh_reg))
    else $error("mode byte changed with strobe off");
  chk_bad_addr: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    doWrite && awAddr_next != LPMC_ADDR_MODE_LOW && awAddr_next != LPMC_ADDR_MODE_HIGH
    |=> s_axi_bresp == LPMC_RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_ready_blocked: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response stands");
  chk_read_answer: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_read_low: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    s_axi_arvalid && s_axi_arready && s_axi_araddr == LPMC_ADDR_MODE_LOW
    |=> s_axi_rdata == {24'h000000, $past(modeLow_reg)} && s_axi_rresp == LPMC_RESP_OKAY)
    else $error("low mode byte read wrong");

endmodule : lpmc_top

/* verif/tb_top.sv */
// Self-checking bench for the regulator power-mode decode block.
// Assumes lpmc_top with its AXI4-Lite slave, one clock, outputs one edge late.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  import lpmc_pkg::*;
  logic        sys_clk, rst, awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady, glp;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0]  wStrb;
  logic [1:0]  bResp, rResp;
  logic [15:0] srcSel;
  logic [7:0]  slotOn, regEn, regLp, expEn, expLp, lo, hi;
  logic [1:0]  modes [8];
  logic [7:0]  pats [3] = '{8'h00, 8'hFF, 8'h5A};
  int          n_mismatch, n_compared, cycles;

  lpmc_top #(.NREG(8)) i_lpmc_top (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .regulator_sequencer_source_select(srcSel), .sequencerSlotOn(slotOn),
    .globalLowPower(glp), .regulatorEnable(regEn), .regulatorLowPower(regLp));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_mismatch++;
      results();
    end
  end

  // Verdict and end of run
  task results;
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Reference decode of one regulator: {enable, lowPower}
  function automatic logic [1:0] expOut(input logic [1:0] m, input logic [1:0] s,
                                        input logic sl, input logic g);
    logic en;
    en = (m != 2'h0) && ((s == LPMC_SRC_SOFT) || sl);
    return {en, en && ((m == 2'h1) ? g : (m == 2'h2))};
  endfunction : expOut

  // AXI write; answers sampled at negedge equal those at the next rising edge
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
    logic awD, wD, bD;
    logic [1:0] r;
    {awD, wD, bD} = 3'b000;
    @(posedge sys_clk);
    {awValid, wValid, bReady} <= 3'b111;
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    while (!bD)
    begin
      @(negedge sys_clk);
      awD = awD | (awValid & awReady);
      wD = wD | (wValid & wReady);
      bD = bValid;
      r = bResp;
      @(posedge sys_clk);
      if (awD) awValid <= 1'b0;
      if (wD) wValid <= 1'b0;
    end
    bReady <= 1'b0;
    `CHK("bresp", er, r)
  endtask : axiWrite

  // AXI read with expected data and response
  task automatic axiRead(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic arD, rD;
    logic [31:0] d;
    logic [1:0] r;
    {arD, rD} = 2'b00;
    @(posedge sys_clk);
    {arValid, rReady} <= 2'b11;
    arAddr <= a;
    while (!rD)
    begin
      @(negedge sys_clk);
      arD = arD | (arValid & arReady);
      rD = rValid;
      d = rData;
      r = rResp;
      @(posedge sys_clk);
      if (arD) arValid <= 1'b0;
    end
    rReady <= 1'b0;
    `CHK("rdata", ed, d)
    `CHK("rresp", er, r)
  endtask : axiRead

  // Main sequence
  initial
  begin
    {rst, awValid, wValid, bReady, arValid, rReady, glp} = 7'b1000000;
    {awAddr, arAddr, wData, wStrb, srcSel, slotOn} = '0;
    {n_mismatch, n_compared, cycles} = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK("enable", 8'h00, regEn)
    `CHK("ready", 3'b111, {awReady, wReady, arReady})
    axiRead(LPMC_ADDR_MODE_LOW, {24'h0, LPMC_RST_MODE_LOW}, LPMC_RESP_OKAY);
    axiRead(LPMC_ADDR_MODE_HIGH, {24'h0, LPMC_RST_MODE_HIGH}, LPMC_RESP_OKAY);
    axiRead(12'h268, 32'h0, LPMC_RESP_SLVERR);
    axiWrite(12'h268, 32'hFF, 4'hF, LPMC_RESP_SLVERR);
    // Each pass rotates the modes so every regulator meets every code
    for (int p = 0; p < 4; p++)
    begin
      for (int n = 0; n < 8; n++) modes[n] = 2'(n + p);
      lo = {modes[0], modes[1], modes[2], modes[3]};
      hi = {modes[4], modes[5], modes[6], modes[7]};
      axiWrite(LPMC_ADDR_MODE_LOW, {24'hABCDEF, lo}, 4'hF, LPMC_RESP_OKAY);
      axiWrite(LPMC_ADDR_MODE_HIGH, {24'h0, hi}, 4'h1, LPMC_RESP_OKAY);
      axiRead(LPMC_ADDR_MODE_LOW, {24'h0, lo}, LPMC_RESP_OKAY);
      axiRead(LPMC_ADDR_MODE_HIGH, {24'h0, hi}, LPMC_RESP_OKAY);
      for (int s = 0; s < 4; s++)
        for (int k = 0; k < 3; k++)
          for (int g = 0; g < 2; g++)
          begin
            @(posedge sys_clk);
            srcSel <= {8{2'(s)}};
            slotOn <= pats[k];
            glp <= 1'(g);
            @(posedge sys_clk);
            @(negedge sys_clk);
            for (int n = 0; n < 8; n++)
              {expEn[n], expLp[n]} = expOut(modes[n], 2'(s), pats[k][n], 1'(g));
            `CHK("enable", expEn, regEn)
            `CHK("lowpower", expLp, regLp)
          end
    end
    // Strobe off leaves the byte alone
    axiWrite(LPMC_ADDR_MODE_LOW, 32'h0, 4'h0, LPMC_RESP_OKAY);
    axiRead(LPMC_ADDR_MODE_LOW, {24'h0, lo}, LPMC_RESP_OKAY);
    // Reset in mid-run restores the fields and drops outputs
    @(posedge sys_clk);
    rst <= 1'b1;
    @(negedge sys_clk);
    `CHK("enable", 8'h00, regEn)
    `CHK("lowpower", 8'h00, regLp)
    `CHK("ready", 3'b111, {awReady, wReady, arReady})
    @(posedge sys_clk);
    rst <= 1'b0;
    axiRead(LPMC_ADDR_MODE_HIGH, {24'h0, LPMC_RST_MODE_HIGH}, LPMC_RESP_OKAY);
    `CHK("enable", 8'h00, regEn)
    results();
  end
endmodule : tb_top
